// ---- hdl/starter_seq_map.svh ----
// Register offsets, field positions, reset values and timing counts
`ifndef STARTER_SEQ_MAP_SVH
`define STARTER_SEQ_MAP_SVH

`define ADDR_CTRL 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_IRQ_STATUS 8'h08
`define ADDR_IRQ_CLEAR 8'h0c
`define ADDR_IRQ_ENABLE 8'h10
`define ADDR_TIMERS 8'h14

`define CTRL_EN_BIT 0
`define CTRL_RESET 1'h1
`define IRQ_ENABLE_RESET 5'h00

`define IRQ_START_DONE 0
`define IRQ_AUX_DONE 1
`define IRQ_CAP_DONE 2
`define IRQ_FUSE 3
`define IRQ_FAULT 4
`define IRQ_W 5

`define DELAY_W 7
`define LINE_CYC_PER_SEC 6'h3c

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ---- hdl/starter_seq_pkg.sv ----
// Types shared by the starter sequencing block
package starter_seq_pkg;

    typedef struct packed {
        logic start_cmd;
        logic fuse_ok;
        logic overload_ok;
        logic bypass_aux_nc;
        logic emerg_bypass;
        logic dual_ramp_in;
        logic cpu_fault;
        logic cpu_run;
        logic cpu_at_speed;
        logic line_sync;
    } pin_s;

    typedef struct packed {
        logic start_delay_unit_select;
        logic aux_delay_unit_select;
        logic cap_contactor_delay_unit_select;
        logic motor_protection_jumper;
        logic dual_adjust_switch;
        logic [6:0] start_delay_switch_bank;
        logic [6:0] aux_start_delay_switch_bank;
        logic [6:0] cap_contactor_delay_switch_bank;
    } cfg_s;

    typedef enum logic {
        CH_IDLE = 1'b0,
        CH_RESP = 1'b1
    } ch_state_e;

endpackage : starter_seq_pkg

// ---- hdl/delay_timer.sv ----
// One settable delay counting line cycles or seconds
`timescale 1ns/1ps
module delay_timer #(
    parameter int W = 7
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic arm,
    input wire logic unit_cycles,
    input wire logic cycle_tick,
    input wire logic sec_tick,
    input wire logic [W-1:0] preset,
    output logic done,
    output logic done_pulse,
    output logic [W-1:0] count
);
    generate
        if (W < 1 || W > 16) begin : g_bad_width
            $error("delay_timer width out of range");
        end
    endgenerate

    logic armed_q;
    logic done_q;
    logic pulse_q;
    logic [W-1:0] cnt_q;
    logic tick;
    logic finish;

    assign tick = unit_cycles ? cycle_tick : sec_tick;
    assign finish = armed_q && !done_q && tick && cnt_q == W'(1);

    always_ff @(posedge aclk) begin
        if (!aresetn || !arm) begin
            armed_q <= 1'b0;
            done_q <= 1'b0;
            cnt_q <= '0;
            pulse_q <= 1'b0;
        end else if (!armed_q) begin
            armed_q <= 1'b1;
            cnt_q <= preset;
            done_q <= preset == '0;
            pulse_q <= preset == '0;
        end else begin
            pulse_q <= finish;
            if (!done_q && tick) begin
                cnt_q <= cnt_q - W'(1);
                done_q <= cnt_q == W'(1);
            end
        end
    end

    assign done = done_q;
    assign done_pulse = pulse_q;
    assign count = cnt_q;
endmodule : delay_timer

// ---- hdl/starter_sequence_delay_timers.sv ----
// Starter sequencing, delay timers, interlocks and AXI4-Lite registers
`timescale 1ns/1ps
`include "starter_seq_map.svh"
module starter_sequence_delay_timers
    import starter_seq_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire pin_s pins,
    input wire cfg_s cfg,
    output logic cpu_start,
    output logic cpu_enable,
    output logic dual_ramp_out,
    output logic aux_start_contacts,
    output logic at_speed_contacts,
    output logic run_contacts,
    output logic bypass_contactor,
    output logic isolation_contactor,
    output logic power_factor_capacitor,
    output logic fuse_indicator,
    output logic fault_indicator,
    output logic start_indicator,
    output logic cap_timed_out_indicator,
    output logic delay_timed_out_indicator,
    output logic irq
);
    generate
        if (ADDR_W < 5 || ADDR_W > 32) begin : g_bad_addr
            $error("ADDR_W out of range");
        end
    endgenerate

    localparam int DW = `DELAY_W;

    // Pins and straps are asynchronous; two stages before any use
    pin_s pins_m_q;
    pin_s pins_s_q;
    cfg_s cfg_m_q;
    cfg_s cfg_s_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pins_m_q <= '0;
            pins_s_q <= '0;
            cfg_m_q <= '0;
            cfg_s_q <= '0;
        end else begin
            pins_m_q <= pins;
            pins_s_q <= pins_m_q;
            cfg_m_q <= cfg;
            cfg_s_q <= cfg_m_q;
        end
    end

    // Timebase from the 60 Hz line: one tick per line cycle
    logic line_prev_q;
    logic [5:0] sec_cnt_q;
    logic cycle_tick;
    logic sec_tick;

    assign cycle_tick = pins_s_q.line_sync && !line_prev_q;
    assign sec_tick = cycle_tick && sec_cnt_q == `LINE_CYC_PER_SEC - 6'h01;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            line_prev_q <= 1'b0;
            sec_cnt_q <= '0;
        end else begin
            line_prev_q <= pins_s_q.line_sync;
            if (sec_tick) begin
                sec_cnt_q <= '0;
            end else if (cycle_tick) begin
                sec_cnt_q <= sec_cnt_q + 6'h01;
            end
        end
    end

    // Interlocks and start qualification
    logic ctrl_en_q;
    logic fuse_open;
    logic at_speed_fb;
    logic emerg;
    logic overload_trip;
    logic fault_any;
    logic start_ok;
    logic soft_start;
    logic direct_start;

    assign fuse_open = !pins_s_q.fuse_ok;
    assign at_speed_fb = !pins_s_q.bypass_aux_nc;
    assign emerg = pins_s_q.emerg_bypass;
    // Without the external overload contact, bypass has no protection
    assign overload_trip = emerg && !pins_s_q.overload_ok;
    assign fault_any = pins_s_q.cpu_fault || fuse_open || overload_trip;
    assign start_ok = pins_s_q.start_cmd && ctrl_en_q && !fault_any;
    assign soft_start = start_ok && !emerg;
    assign direct_start = start_ok && emerg;

    logic start_done;
    logic aux_done;
    logic cap_done;
    logic start_pulse;
    logic aux_pulse;
    logic cap_pulse;
    logic [DW-1:0] start_cnt;
    logic [DW-1:0] aux_cnt;
    logic [DW-1:0] cap_cnt;

    // Jumper absent reads 0, which selects seconds
    delay_timer #(.W(DW)) u_start_delay (
        .aclk(aclk),
        .aresetn(aresetn),
        .arm(soft_start),
        .unit_cycles(cfg_s_q.start_delay_unit_select),
        .cycle_tick(cycle_tick),
        .sec_tick(sec_tick),
        .preset(cfg_s_q.start_delay_switch_bank),
        .done(start_done),
        .done_pulse(start_pulse),
        .count(start_cnt)
    );

    delay_timer #(.W(DW)) u_aux_delay (
        .aclk(aclk),
        .aresetn(aresetn),
        .arm(start_ok),
        .unit_cycles(cfg_s_q.aux_delay_unit_select),
        .cycle_tick(cycle_tick),
        .sec_tick(sec_tick),
        .preset(cfg_s_q.aux_start_delay_switch_bank),
        .done(aux_done),
        .done_pulse(aux_pulse),
        .count(aux_cnt)
    );

    delay_timer #(.W(DW)) u_cap_delay (
        .aclk(aclk),
        .aresetn(aresetn),
        .arm(start_ok && at_speed_fb),
        .unit_cycles(cfg_s_q.cap_contactor_delay_unit_select),
        .cycle_tick(cycle_tick),
        .sec_tick(sec_tick),
        .preset(cfg_s_q.cap_contactor_delay_switch_bank),
        .done(cap_done),
        .done_pulse(cap_pulse),
        .count(cap_cnt)
    );

    // Contact and indicator outputs, all registered
    logic at_speed_cmd;
    logic run_hold;

    assign at_speed_cmd = soft_start && pins_s_q.cpu_at_speed;
    // Run stays on after start drops, for the deceleration ramp
    assign run_hold = pins_s_q.cpu_run && !fault_any;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cpu_start <= 1'b0;
            cpu_enable <= 1'b1;
            dual_ramp_out <= 1'b0;
            aux_start_contacts <= 1'b0;
            at_speed_contacts <= 1'b0;
            run_contacts <= 1'b0;
            bypass_contactor <= 1'b0;
            isolation_contactor <= 1'b0;
            power_factor_capacitor <= 1'b0;
        end else begin
            cpu_start <= start_done;
            cpu_enable <= !(emerg && cfg_s_q.motor_protection_jumper);
            dual_ramp_out <= cfg_s_q.dual_adjust_switch
                && pins_s_q.dual_ramp_in;
            aux_start_contacts <= aux_done;
            at_speed_contacts <= at_speed_cmd;
            run_contacts <= run_hold;
            bypass_contactor <= at_speed_cmd || direct_start;
            isolation_contactor <= run_hold || direct_start;
            power_factor_capacitor <= cap_done;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fuse_indicator <= 1'b0;
            fault_indicator <= 1'b0;
            start_indicator <= 1'b0;
            cap_timed_out_indicator <= 1'b0;
            delay_timed_out_indicator <= 1'b0;
        end else begin
            fuse_indicator <= fuse_open;
            fault_indicator <= fault_any;
            start_indicator <= start_ok;
            cap_timed_out_indicator <= cap_done;
            delay_timed_out_indicator <= aux_done;
        end
    end

    // Interrupt events: timer expiries and rising fault conditions
    logic fuse_prev_q;
    logic fault_prev_q;
    logic [`IRQ_W-1:0] irq_ev;
    logic [`IRQ_W-1:0] irq_status_q;
    logic [`IRQ_W-1:0] irq_enable_q;
    logic [`IRQ_W-1:0] irq_clear;

    always_comb begin
        irq_ev = '0;
        irq_ev[`IRQ_START_DONE] = start_pulse;
        irq_ev[`IRQ_AUX_DONE] = aux_pulse;
        irq_ev[`IRQ_CAP_DONE] = cap_pulse;
        irq_ev[`IRQ_FUSE] = fuse_open && !fuse_prev_q;
        irq_ev[`IRQ_FAULT] = fault_any && !fault_prev_q;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            // Synced pins reset low, so both conditions read true at first
            fuse_prev_q <= 1'b1;
            fault_prev_q <= 1'b1;
            irq_status_q <= '0;
        end else begin
            fuse_prev_q <= fuse_open;
            fault_prev_q <= fault_any;
            // A new event in the clearing cycle survives
            irq_status_q <= (irq_status_q & ~irq_clear) | irq_ev;
        end
    end

    assign irq = |(irq_status_q & irq_enable_q);

    // AXI4-Lite write channel: address and data taken in either order
    ch_state_e wr_st_q;
    logic aw_held_q;
    logic w_held_q;
    logic [ADDR_W-1:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic [1:0] bresp_q;
    logic do_write;
    logic [7:0] wa;

    assign s_axi_awready = !aw_held_q && wr_st_q == CH_IDLE;
    assign s_axi_wready = !w_held_q && wr_st_q == CH_IDLE;
    assign do_write = aw_held_q && w_held_q;
    assign wa = 8'({aw_addr_q[ADDR_W-1:2], 2'b00});
    assign s_axi_bvalid = wr_st_q == CH_RESP;
    assign s_axi_bresp = bresp_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_st_q <= CH_IDLE;
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            aw_addr_q <= '0;
            w_data_q <= '0;
            w_strb_q <= '0;
            bresp_q <= `RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            case (wr_st_q)
                CH_IDLE: begin
                    if (do_write) begin
                        aw_held_q <= 1'b0;
                        w_held_q <= 1'b0;
                        wr_st_q <= CH_RESP;
                        case (wa)
                            `ADDR_CTRL, `ADDR_IRQ_CLEAR,
                            `ADDR_IRQ_ENABLE: bresp_q <= `RESP_OKAY;
                            default: bresp_q <= `RESP_SLVERR;
                        endcase
                    end
                end
                CH_RESP: begin
                    if (s_axi_bready) begin
                        wr_st_q <= CH_IDLE;
                    end
                end
                default: wr_st_q <= CH_IDLE;
            endcase
        end
    end

    logic wr_lane0;

    assign wr_lane0 = do_write && wr_st_q == CH_IDLE && w_strb_q[0];
    assign irq_clear = (wr_lane0 && wa == `ADDR_IRQ_CLEAR)
        ? w_data_q[`IRQ_W-1:0] : '0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_en_q <= `CTRL_RESET;
            irq_enable_q <= `IRQ_ENABLE_RESET;
        end else if (wr_lane0) begin
            if (wa == `ADDR_CTRL) begin
                ctrl_en_q <= w_data_q[`CTRL_EN_BIT];
            end
            if (wa == `ADDR_IRQ_ENABLE) begin
                irq_enable_q <= w_data_q[`IRQ_W-1:0];
            end
        end
    end

    // AXI4-Lite read channel
    ch_state_e rd_st_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic [31:0] rd_mux;
    logic [1:0] rd_resp;
    logic [7:0] ra;

    assign ra = 8'({s_axi_araddr[ADDR_W-1:2], 2'b00});
    assign s_axi_arready = rd_st_q == CH_IDLE;
    assign s_axi_rvalid = rd_st_q == CH_RESP;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    always_comb begin
        rd_mux = '0;
        rd_resp = `RESP_OKAY;
        case (ra)
            `ADDR_CTRL: rd_mux[`CTRL_EN_BIT] = ctrl_en_q;
            `ADDR_STATUS: rd_mux[11:0] = {start_ok, emerg, at_speed_fb,
                fuse_open, fault_any, cpu_enable, run_contacts,
                isolation_contactor, bypass_contactor,
                power_factor_capacitor, aux_start_contacts, cpu_start};
            `ADDR_IRQ_STATUS: rd_mux[`IRQ_W-1:0] = irq_status_q;
            `ADDR_IRQ_CLEAR: rd_mux = '0;
            `ADDR_IRQ_ENABLE: rd_mux[`IRQ_W-1:0] = irq_enable_q;
            `ADDR_TIMERS: rd_mux[22:0] = {cap_cnt, 1'b0, aux_cnt, 1'b0,
                start_cnt};
            default: rd_resp = `RESP_SLVERR;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_st_q <= CH_IDLE;
            rdata_q <= '0;
            rresp_q <= `RESP_OKAY;
        end else begin
            case (rd_st_q)
                CH_IDLE: begin
                    if (s_axi_arvalid) begin
                        rdata_q <= rd_mux;
                        rresp_q <= rd_resp;
                        rd_st_q <= CH_RESP;
                    end
                end
                CH_RESP: begin
                    if (s_axi_rready) begin
                        rd_st_q <= CH_IDLE;
                    end
                end
                default: rd_st_q <= CH_IDLE;
            endcase
        end
    end
endmodule : starter_sequence_delay_timers

// ---- bench/starter_far_side.sv ----
// Far side model: CPU board, contactor feedback and line sync
`timescale 1ns/1ps
module starter_far_side
    import starter_seq_pkg::*;
#(
    parameter int LINE_HALF = 6,
    parameter int RAMP = 20,
    parameter int DECEL = 30
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire pin_s ctl,
    input wire logic cpu_start,
    input wire logic bypass_contactor,
    output pin_s pins
);
    logic [7:0] ph_q = 8'h00;
    logic sync_q = 1'b0;
    logic [7:0] ramp_q, decel_q;
    logic [1:0] fb_q = 2'h0;
    // Mains sync runs free, reset or not
    always_ff @(posedge aclk) begin
        ph_q <= (ph_q == 8'(LINE_HALF - 1)) ? 8'h00 : ph_q + 8'h01;
        sync_q <= sync_q ^ (ph_q == 8'(LINE_HALF - 1));
    end
    always_ff @(posedge aclk) begin
        if (!aresetn || !cpu_start) begin
            ramp_q <= 8'h00;
        end else if (ramp_q != 8'(RAMP)) begin
            ramp_q <= ramp_q + 8'h01;
        end
    end
    // Run contacts stay closed while the motor coasts down
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            decel_q <= 8'h00;
        end else if (cpu_start) begin
            decel_q <= 8'(DECEL);
        end else if (decel_q != 8'h00) begin
            decel_q <= decel_q - 8'h01;
        end
    end
    // Armature lags the coil by two cycles
    always_ff @(posedge aclk) begin
        fb_q <= {fb_q[0], bypass_contactor && aresetn};
    end
    always_comb begin
        pins = ctl;
        pins.cpu_run = cpu_start || decel_q != 8'h00;
        pins.cpu_at_speed = ramp_q == 8'(RAMP);
        pins.bypass_aux_nc = !fb_q[1];
        pins.line_sync = sync_q;
    end
endmodule : starter_far_side

// ---- bench/starter_seq_asserts.sv ----
// Checker on the starter sequencing ports
`timescale 1ns/1ps
module starter_seq_asserts
    import starter_seq_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire pin_s pins,
    input wire cfg_s cfg,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic cpu_start,
    input wire logic cpu_enable,
    input wire logic dual_ramp_out,
    input wire logic aux_start_contacts,
    input wire logic run_contacts,
    input wire logic power_factor_capacitor,
    input wire logic fuse_indicator,
    input wire logic fault_indicator,
    input wire logic cap_timed_out_indicator,
    input wire logic delay_timed_out_indicator
);
    logic [1:0] up_q;
    logic fault_w, dual_w, lock_w;
    assign fault_w = pins.cpu_fault || !pins.fuse_ok
        || (pins.emerg_bypass && !pins.overload_ok);
    assign dual_w = cfg.dual_adjust_switch && pins.dual_ramp_in;
    assign lock_w = pins.emerg_bypass && cfg.motor_protection_jumper;
    // Pin history valid three edges after reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            up_q <= 2'h0;
        end else if (up_q != 2'h3) begin
            up_q <= up_q + 2'h1;
        end
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_fault_held;
        fault_indicator [*3];
    endsequence
    property p_fuse;
        up_q == 2'h3 |-> fuse_indicator == !$past(pins.fuse_ok, 3);
    endproperty
    property p_dual;
        up_q == 2'h3 |-> dual_ramp_out == $past(dual_w, 3);
    endproperty
    property p_lock;
        up_q == 2'h3 |-> cpu_enable == !$past(lock_w, 3);
    endproperty
    property p_fault;
        up_q == 2'h3 |-> fault_indicator == $past(fault_w, 3);
    endproperty
    property p_run;
        up_q == 2'h3 |->
            run_contacts == ($past(pins.cpu_run, 3) && !fault_indicator);
    endproperty
    property p_cap_ind;
        cap_timed_out_indicator == power_factor_capacitor;
    endproperty
    property p_dly_ind;
        delay_timed_out_indicator == aux_start_contacts;
    endproperty
    property p_cancel;
        s_fault_held |-> !cpu_start && !aux_start_contacts;
    endproperty
    property p_bhold;
        s_axi_bvalid && !s_axi_bready |=>
            s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_fuse: assert property (p_fuse)
        else $error("fuse indicator");
    a_dual: assert property (p_dual)
        else $error("dual ramp");
    a_lock: assert property (p_lock)
        else $error("cpu enable");
    a_fault: assert property (p_fault)
        else $error("fault indicator");
    a_run: assert property (p_run)
        else $error("run contacts");
    a_cap_ind: assert property (p_cap_ind)
        else $error("cap indicator");
    a_dly_ind: assert property (p_dly_ind)
        else $error("delay indicator");
    a_cancel: assert property (p_cancel)
        else $error("output under fault");
    a_bhold: assert property (p_bhold)
        else $error("bresp dropped");
endmodule : starter_seq_asserts

bind starter_sequence_delay_timers starter_seq_asserts u_chk (.*);

// ---- bench/starter_sequence_delay_timers_tb.sv ----
// Self-checking bench for the starter sequencing block
`timescale 1ns/1ps
`include "starter_seq_map.svh"
module starter_sequence_delay_timers_tb;
    import starter_seq_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    pin_s ctl, pins;
    cfg_s cfg;
    logic cpu_start, cpu_enable, dual_ramp_out, aux_start_contacts;
    logic at_speed_contacts, run_contacts, bypass_contactor;
    logic isolation_contactor, power_factor_capacitor, fuse_indicator;
    logic fault_indicator, start_indicator, cap_timed_out_indicator;
    logic delay_timed_out_indicator, irq;
    logic [3:0] outv, lv;
    int error_cnt = 0, checks_done = 0;
    // {fuse,ovl,emerg,jumper,dual_sw,dual_in,cpu_fault}
    // then {fuse_ind,fault_ind,cpu_en,dual_out}
    logic [10:0] rows [8] = '{11'b1100110_0011, 11'b1100010_0010,
        11'b0100000_1110, 11'b1100001_0110, 11'b1011000_0100,
        11'b1110000_0010, 11'b1000000_0010, 11'b1100000_0010};
    assign outv = {bypass_contactor, power_factor_capacitor,
        aux_start_contacts, cpu_start};
    assign lv = {fuse_indicator, fault_indicator, cpu_enable, dual_ramp_out};
    always #4 aclk = !aclk;
    starter_sequence_delay_timers u_dut (.*);
    starter_far_side u_far (.aclk, .aresetn, .ctl, .cpu_start,
        .bypass_contactor, .pins);
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : test_done
    task automatic chk(input string nm, input logic [31:0] e, g);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic chk_rng(input string nm, input int lo, hi, c);
        checks_done++;
        if (c < lo || c > hi) begin
            error_cnt++;
            $display("unexpected %s: expected %0d..%0d seen %0d", nm, lo,
                hi, c);
        end
    endtask : chk_rng
    task automatic tmo(input logic ok);
        if (!ok) begin
            error_cnt++;
            $display("unexpected wait: expected answer seen timeout");
            test_done();
        end
    endtask : tmo
    task automatic cyc(input int k);
        repeat (k) @(posedge aclk);
    endtask : cyc
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
            input logic [1:0] er);
        int n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && n < 50);
        s_axi_bready <= 1'b0;
        tmo(s_axi_bvalid === 1'b1);
        chk("bresp", er, s_axi_bresp);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
            output logic [1:0] r);
        int n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && n < 50);
        s_axi_rready <= 1'b0;
        tmo(s_axi_rvalid === 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask : rd
    // Counts line cycles until the chosen output closes
    task automatic count_to(input int sel, output int c);
        int n = 0;
        logic p;
        c = 0;
        p = pins.line_sync;
        while (outv[sel] !== 1'b1 && n < 3000) begin
            @(posedge aclk);
            n++;
            if (pins.line_sync === 1'b1 && p === 1'b0) c++;
            p = pins.line_sync;
        end
        tmo(outv[sel] === 1'b1);
    endtask : count_to
    // Mid line cycle, so the first tick lands after the load
    task automatic at_fall();
        int n = 0;
        logic p = 1'b0;
        do begin
            p = pins.line_sync;
            @(posedge aclk);
            n++;
        end while (!(p === 1'b1 && pins.line_sync === 1'b0) && n < 40);
        tmo(n < 40);
    endtask : at_fall
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        int c1, c2, c3, c4;
        ctl = 10'h180;
        cfg = '0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`ADDR_CTRL, d, r);
        chk("ctrl", 32'h0000_0001, d);
        rd(`ADDR_IRQ_ENABLE, d, r);
        chk("irq_en", 32'h0000_0000, d);
        rd(8'h18, d, r);
        chk("hole_resp", `RESP_SLVERR, r);
        chk("hole_data", 32'h0000_0000, d);
        wr(8'h18, 32'h0000_0001, `RESP_SLVERR);
        $display("test reset done");
        foreach (rows[i]) begin
            {ctl.fuse_ok, ctl.overload_ok, ctl.emerg_bypass,
                cfg.motor_protection_jumper, cfg.dual_adjust_switch,
                ctl.dual_ramp_in, ctl.cpu_fault} <= rows[i][10:4];
            cyc(6);
            chk("levels", rows[i][3:0], lv);
        end
        $display("test levels done");
        cfg <= {5'b11100, 7'h05, 7'h40, 7'h06};
        wr(`ADDR_IRQ_ENABLE, 32'h0000_0001, `RESP_OKAY);
        at_fall();
        ctl.start_cmd <= 1'b1;
        count_to(0, c1);
        chk_rng("start_cycles", 5, 5, c1);
        count_to(3, c2);
        chk("at_speed", 2'b11,
            {at_speed_contacts, isolation_contactor});
        count_to(2, c3);
        chk_rng("cap_cycles", 6, 7, c3);
        count_to(1, c4);
        chk_rng("aux_cycles", 64, 64, c1 + c2 + c3 + c4);
        chk("indicators", 4'hf, {start_indicator, cap_timed_out_indicator,
            delay_timed_out_indicator, run_contacts});
        $display("test cycles done");
        chk("irq_set", 1'b1, irq);
        wr(`ADDR_IRQ_ENABLE, 32'h0000_0000, `RESP_OKAY);
        chk("irq_mask", 1'b0, irq);
        rd(`ADDR_IRQ_STATUS, d, r);
        chk("irq_status", 1'b1, d[`IRQ_START_DONE]);
        wr(`ADDR_IRQ_ENABLE, 32'h0000_0001, `RESP_OKAY);
        wr(`ADDR_IRQ_CLEAR, 32'h0000_0001, `RESP_OKAY);
        chk("irq_clear", 1'b0, irq);
        $display("test irq done");
        ctl.start_cmd <= 1'b0;
        cyc(12);
        chk("decel", 3'b110,
            {run_contacts, isolation_contactor, cpu_start});
        cyc(40);
        chk("stopped", 1'b0, run_contacts);
        cfg <= {5'b01100, 7'h02, 7'h00, 7'h06};
        at_fall();
        ctl.start_cmd <= 1'b1;
        count_to(1, c1);
        chk_rng("aux_zero", 0, 0, c1);
        count_to(0, c2);
        chk_rng("start_seconds", 61, 120, c2);
        ctl.start_cmd <= 1'b0;
        $display("test seconds done");
        cfg <= {5'b11100, 7'h0a, 7'h0a, 7'h06};
        for (int i = 0; i < 3; i++) begin
            if (i == 2) wr(`ADDR_CTRL, 32'h0000_0000, `RESP_OKAY);
            cyc(10);
            ctl.start_cmd <= 1'b1;
            cyc(40);
            if (i == 0) ctl.start_cmd <= 1'b0;
            if (i == 1) ctl.cpu_fault <= 1'b1;
            cyc(200);
            chk("cancel", 3'b000,
                {cpu_start, aux_start_contacts, start_indicator});
            ctl.start_cmd <= 1'b0;
            ctl.cpu_fault <= 1'b0;
        end
        wr(`ADDR_CTRL, 32'h0000_0001, `RESP_OKAY);
        $display("test cancel done");
        ctl.emerg_bypass <= 1'b1;
        cfg.motor_protection_jumper <= 1'b1;
        ctl.start_cmd <= 1'b1;
        cyc(10);
        chk("bypass", 4'b1100, {bypass_contactor, isolation_contactor,
            cpu_start, cpu_enable});
        $display("test bypass done");
        test_done();
    end
endmodule : starter_sequence_delay_timers_tb
